// *** dwl_level.sv ***
`timescale 1ns/1ps
`include "dwl_consts.svh"
// Overview of operation
// - MR1 bit 7 enters/leaves write leveling
// - MR1 bit 12 disables output buffer
// - Leveling ODT switches strobe termination only
// - Strobe rise samples clock onto data
// - Separate feedback per lane, lines 0/8
// - Non-prime lines written low at each prime-only feedback
module dwl_level (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire dwl_pkg::dwl_cmd_t  cmd,
  input  wire logic               cmd_valid,
  input  wire logic               cke,
  input  wire logic               odt,
  input  wire logic               freq_chg,
  input  wire logic [1:0]         strobe_rise,
  input  wire logic               ck_level,
  output logic [15:0]             dq_out,
  output logic [1:0]              dq_oe,
  output logic                    dqs_term,
  output logic                    dq_term,
  output logic                    dll_locked,
  input  wire logic [3:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [3:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready
);
  import dwl_pkg::*;

  localparam int WLO_C = `DWL_WLO_CYC;

  dwl_state_t  state_q;          // Power state
  logic [15:0] mr0_q;            // Mode register 0 shadow
  logic [15:0] mr1_q;            // Mode register 1 shadow
  logic        all_dq_q;         // Feedback on all lines
  logic        ill_freq_q;       // Sticky illegal clock change
  logic [9:0]  lock_cnt_q;       // DLL relock countdown
  logic        locked_q;         // DLL locked
  logic [1:0]  samp_q;           // Clock level per lane
  logic [3:0]  wlo_cnt_q [2];    // Output delay per lane
  logic [15:0] dq_q;             // Feedback lines
  logic [1:0]  dq_oe_q;          // Lane drive enables
  logic        dqs_term_q;       // Strobe termination
  logic        dq_term_q;        // Data termination
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_full_q, w_full_q;
  logic [3:0]  aw_addr_q;        // Held write address
  logic [31:0] w_data_q;         // Held write data
  logic [3:0]  w_strb_q;         // Held byte enables
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        mrs_fire;         // Mode register write now
  logic        wr_fire;          // Register write now
  logic        wlev, qoff, rtt_en, dll_off;

  // Decoded mode bits
  assign wlev    = mr1_q[`DWL_MR1_WLEV];
  assign qoff    = mr1_q[`DWL_MR1_QOFF];
  assign dll_off = mr1_q[`DWL_MR1_DLL_OFF];
  assign rtt_en  = mr1_q[`DWL_MR1_RTT_B0] | mr1_q[`DWL_MR1_RTT_B1] | mr1_q[`DWL_MR1_RTT_B2];
  // Mode register commands only count with CKE high
  assign mrs_fire = ce && cmd_valid && cke && (cmd.kind == CMD_MRS) && (state_q == ST_IDLE);
  assign wr_fire  = ce && aw_full_q && w_full_q && !bvalid_q;

  // Mode register shadows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mr0_q <= `DWL_MR_RST;
      mr1_q <= `DWL_MR_RST;
    end else if (mrs_fire) begin
      if (cmd.ba == `DWL_BA_MR0) begin
        mr0_q <= cmd.addr;
      end
      // Bit 7 enters and leaves leveling, bit 12 gates the outputs
      if (cmd.ba == `DWL_BA_MR1) begin
        mr1_q <= cmd.addr;
      end
    end
  end

  // Power state tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          // Falling CKE picks self-refresh or power-down
          if (!cke && cmd_valid && cmd.kind == CMD_SRE) begin
            state_q <= ST_SREF;
          end else if (!cke) begin
            state_q <= ST_PPD;
          end
        end
        ST_SREF, ST_PPD: begin
          if (cke) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // DLL relock timer; a clock change drops lock until the next MR0 DLL reset command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_q <= 10'h000;
      locked_q   <= 1'b0;
    end else if (ce) begin
      if (dll_off || freq_chg) begin
        lock_cnt_q <= 10'h000;
        locked_q   <= 1'b0;
      end else if (mrs_fire && cmd.ba == `DWL_BA_MR0 && cmd.addr[`DWL_MR0_DLL_RST]) begin
        lock_cnt_q <= `DWL_DLLK_CYC;
        locked_q   <= 1'b0;
      end else if (lock_cnt_q != 10'h000) begin
        lock_cnt_q <= lock_cnt_q - 10'h001;
        if (lock_cnt_q == 10'h001) begin
          locked_q <= 1'b1;
        end
      end
    end
  end

  // Sticky flag for clock change outside the two legal states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ill_freq_q <= 1'b0;
    end else if (ce) begin
      // Set wins over a software clear in the same cycle
      if (freq_chg && state_q == ST_IDLE) begin
        ill_freq_q <= 1'b1;
      end else if (wr_fire && aw_addr_q == `DWL_OFF_STATUS && w_strb_q[0]
                   && w_data_q[`DWL_ST_ILLFREQ]) begin
        ill_freq_q <= 1'b0;
      end
    end
  end

  // Termination: leveling gives ODT to the strobes only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dqs_term_q <= 1'b0;
      dq_term_q  <= 1'b0;
    end else if (ce) begin
      if (wlev) begin
        dqs_term_q <= odt;
        dq_term_q  <= 1'b0;
      end else begin
        dqs_term_q <= odt && rtt_en;
        dq_term_q  <= odt && rtt_en;
      end
    end
  end

  // Per lane: sample clock on strobe rise, present after output delay
  genvar ln;
  generate
    for (ln = 0; ln < 2; ln++) begin : g_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          samp_q[ln]    <= 1'b0;
          wlo_cnt_q[ln] <= 4'h0;
          dq_q[ln*8+:8] <= 8'h00;
        end else if (ce) begin
          if (!wlev) begin
            wlo_cnt_q[ln] <= 4'h0;
            dq_q[ln*8+:8] <= 8'h00;
          end else begin
            if (strobe_rise[ln]) begin
              samp_q[ln]    <= ck_level;
              wlo_cnt_q[ln] <= 4'(WLO_C);
            end else if (wlo_cnt_q[ln] != 4'h0) begin
              wlo_cnt_q[ln] <= wlo_cnt_q[ln] - 4'h1;
            end
            // Lane feedback on its prime line, or on every line
            if (wlo_cnt_q[ln] == 4'h1 && !strobe_rise[ln]) begin
              dq_q[ln*8]       <= samp_q[ln];
              dq_q[ln*8+1+:7]  <= all_dq_q ? {7{samp_q[ln]}} : 7'h00;
            end
          end
        end
      end
      // Output buffer off when qoff set, and always outside leveling
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dq_oe_q[ln] <= 1'b0;
        end else if (ce) begin
          dq_oe_q[ln] <= wlev && !qoff;
        end
      end
    end
  endgenerate

  // Bus write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DWL_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready_q) begin
        aw_addr_q <= awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (aw_addr_q == `DWL_OFF_CTRL || aw_addr_q == `DWL_OFF_STATUS
                     || aw_addr_q == `DWL_OFF_MR1) ? `DWL_RESP_OKAY : `DWL_RESP_SLVERR;
      end
      // Reopen both channels once the response is taken
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Control register: feedback width choice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      all_dq_q <= 1'b0;
    end else if (wr_fire && aw_addr_q == `DWL_OFF_CTRL && w_strb_q[0]) begin
      all_dq_q <= w_data_q[`DWL_CTRL_ALLDQ];
    end
  end

  // Read channel; one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `DWL_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= `DWL_RESP_OKAY;
        case (araddr)
          `DWL_OFF_CTRL:   rdata_q <= {31'h0, all_dq_q};
          `DWL_OFF_STATUS: rdata_q <= {24'h0, ill_freq_q, locked_q, dll_off, qoff,
                                       wlev, 1'b0, state_q};
          `DWL_OFF_MR1:    rdata_q <= {16'h0, mr1_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= `DWL_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Outputs straight from flops
  assign dq_out     = dq_q;
  assign dq_oe      = dq_oe_q;
  assign dqs_term   = dqs_term_q;
  assign dq_term    = dq_term_q;
  assign dll_locked = locked_q;
  assign awready    = awready_q;
  assign wready     = wready_q;
  assign bvalid     = bvalid_q;
  assign bresp      = bresp_q;
  assign arready    = arready_q;
  assign rvalid     = rvalid_q;
  assign rdata      = rdata_q;
  assign rresp      = rresp_q;

  // Checks on leveling behaviour
  property p_wlev_entry;
    @(posedge aclk) disable iff (!aresetn)
      (mrs_fire && cmd.ba == `DWL_BA_MR1) |=> (wlev == $past(cmd.addr[`DWL_MR1_WLEV]));
  endproperty
  a_wlev_entry: assert property (p_wlev_entry) else $error("leveling bit not taken");

  property p_qoff;
    @(posedge aclk) disable iff (!aresetn)
      (ce && wlev && qoff) |=> (dq_oe_q == 2'b00);
  endproperty
  a_qoff: assert property (p_qoff) else $error("lane driven with buffer off");

  property p_term;
    @(posedge aclk) disable iff (!aresetn)
      (ce && wlev) |=> (!dq_term_q && dqs_term_q == $past(odt));
  endproperty
  a_term: assert property (p_term) else $error("leveling termination wrong");

  // One-cycle output delay here, so feedback shows two edges after the strobe
  property p_fb_low;
    @(posedge aclk) disable iff (!aresetn || !ce)
      (wlev && strobe_rise[0] && !strobe_rise[1]) ##1 (!strobe_rise[0] && wlev)[*1]
      |=> dq_q[0] == $past(ck_level, 2);
  endproperty
  a_fb_low: assert property (p_fb_low) else $error("lower lane feedback wrong");

  property p_fb_up;
    @(posedge aclk) disable iff (!aresetn || !ce)
      (wlev && strobe_rise[1]) ##1 (!strobe_rise[1] && wlev)[*1]
      |=> dq_q[8] == $past(ck_level, 2);
  endproperty
  a_fb_up: assert property (p_fb_up) else $error("upper lane feedback wrong");

  property p_prime_only;
    @(posedge aclk) disable iff (!aresetn)
      !all_dq_q |-> (dq_q[7:1] == 7'h00 && dq_q[15:9] == 7'h00);
  endproperty
  a_prime_only: assert property (p_prime_only) else $error("non-prime line high");

  c_wlev: cover property (@(posedge aclk) disable iff (!aresetn) $rose(wlev));
  c_lock: cover property (@(posedge aclk) disable iff (!aresetn) $rose(locked_q));
  c_ppd:  cover property (@(posedge aclk) disable iff (!aresetn) state_q == ST_PPD ##1 cke);
endmodule

// *** dwl_consts.svh ***
`ifndef DWL_CONSTS_SVH
`define DWL_CONSTS_SVH
// Clock and timing
`define DWL_CLK_NS       10
`define DWL_WLO_NS       9
`define DWL_WLO_CYC      (((`DWL_WLO_NS) / (`DWL_CLK_NS)) < 1 ? 1 : ((`DWL_WLO_NS) / (`DWL_CLK_NS)))
`define DWL_DLLK_CYC     10'd512
// Mode register select codes
`define DWL_BA_MR0       3'h0
`define DWL_BA_MR1       3'h1
// Mode register bit positions
`define DWL_MR1_DLL_OFF  0
`define DWL_MR1_RTT_B0   2
`define DWL_MR1_RTT_B1   6
`define DWL_MR1_WLEV     7
`define DWL_MR1_RTT_B2   9
`define DWL_MR1_QOFF     12
`define DWL_MR0_DLL_RST  8
// Register byte offsets
`define DWL_OFF_CTRL     4'h0
`define DWL_OFF_STATUS   4'h4
`define DWL_OFF_MR1      4'h8
// Field positions
`define DWL_CTRL_ALLDQ   0
`define DWL_ST_ILLFREQ   7
// Reset values and response codes
`define DWL_MR_RST       16'h0000
`define DWL_RESP_OKAY    2'h0
`define DWL_RESP_SLVERR  2'h2
`endif

// *** dwl_pkg.sv ***
package dwl_pkg;
  // Power state of the device
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SREF = 2'b01,
    ST_PPD  = 2'b10
  } dwl_state_t;
  // Decoded command kind
  typedef enum logic [1:0] {
    CMD_NOP   = 2'b00,
    CMD_MRS   = 2'b01,
    CMD_SRE   = 2'b10,
    CMD_OTHER = 2'b11
  } dwl_cmd_kind_t;
  // One registered command
  typedef struct packed {
    dwl_cmd_kind_t kind;
    logic [2:0]    ba;
    logic [15:0]   addr;
  } dwl_cmd_t;
  // Leveling feedback onto the data lines
  typedef struct packed {
    logic [15:0] dq;
    logic [1:0]  oe;
  } dwl_fb_t;
endpackage

// *** dwl_ctrl_model.sv ***
`timescale 1ns/1ps
// Controller stand-in: every pin moves just after a rising edge
module dwl_ctrl_model (
  input  wire logic         aclk,
  output dwl_pkg::dwl_cmd_t cmd,
  output logic              cmd_valid,
  output logic              cke,
  output logic              odt,
  output logic              freq_chg,
  output logic [1:0]        strobe_rise,
  output logic              ck_level
);
  import dwl_pkg::*;
  // Quiet pins at time zero, CKE high
  initial begin
    cmd = '0;
    cmd_valid = 1'b0;
    cke = 1'b1;
    odt = 1'b0;
    freq_chg = 1'b0;
    strobe_rise = 2'b00;
    ck_level = 1'b0;
  end
  // Mode write; address garbled afterwards so stale values never help
  task automatic mrs(input logic [2:0] b, input logic [15:0] a);
    @(posedge aclk);
    cmd <= '{kind: CMD_MRS, ba: b, addr: a};
    cmd_valid <= 1'b1;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd.addr <= ~a;
  endtask
  // Termination pin; set to v at the next rising edge
  task automatic set_odt(input logic v);
    @(posedge aclk);
    odt <= v;
  endtask
  // One rising strobe edge on one lane, clock seen at level v
  task automatic pulse(input int lane, input logic v);
    @(posedge aclk);
    strobe_rise[lane] <= 1'b1;
    ck_level <= v;
    @(posedge aclk);
    strobe_rise <= 2'b00;
    ck_level <= ~v;
  endtask
  // Leave idle with ODT low; entry command picks self-refresh
  task automatic low_power(input logic sref);
    @(posedge aclk);
    cke <= 1'b0;
    odt <= 1'b0;
    cmd.kind <= sref ? CMD_SRE : CMD_NOP;
    cmd_valid <= sref;
    @(posedge aclk);
    cmd_valid <= 1'b0;
  endtask
  // Stop-entry wait, clock change, then stable restart period
  task automatic clk_change();
    repeat (4) @(posedge aclk);
    freq_chg <= 1'b1;
    @(posedge aclk);
    freq_chg <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // Exit; CKE then stays high through any relock
  task automatic wake();
    @(posedge aclk);
    cke <= 1'b1;
  endtask
endmodule

// *** dwl_level_tb_top.sv ***
`timescale 1ns/1ps
// Bench: reference model compared with the device at every result
module dwl_level_tb_top;
  import dwl_pkg::*;
  // Bench-driven inputs
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic        v = 1'b0;
  logic [1:0]  fb_last = 2'b00, dly_lock = 2'b00, last_v = 2'b00;
  logic [31:0] wdata = 32'h0, rdata;
  // Design and partner outputs
  logic        awready, wready, bvalid, arready, rvalid, dqs_term, dq_term, dll_locked;
  logic        cmd_valid, cke, odt, freq_chg, ck_level;
  logic [1:0]  bresp, rresp, dq_oe, strobe_rise;
  logic [15:0] dq_out;
  dwl_cmd_t    cmd;
  // Counters and model state
  int          error_cnt = 0, total_checks = 0, i, lane;
  logic [1:0]  st = 2'h0;
  logic        ill = 1'b0, lock = 1'b0, alldq = 1'b0;
  logic [15:0] mr1 = 16'h0, rnd = 16'hdb8d;
  // 100 MHz
  always #5 aclk = ~aclk;
  dwl_ctrl_model dwl_ctrl_model_i (.aclk(aclk), .cmd(cmd), .cmd_valid(cmd_valid), .cke(cke),
    .odt(odt), .freq_chg(freq_chg), .strobe_rise(strobe_rise), .ck_level(ck_level));
  // Write strobes full except for one write with byte lane 0 off
  dwl_level dwl_level_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .cmd(cmd),
    .cmd_valid(cmd_valid), .cke(cke), .odt(odt), .freq_chg(freq_chg),
    .strobe_rise(strobe_rise), .ck_level(ck_level), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_term(dqs_term), .dq_term(dq_term), .dll_locked(dll_locked), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // Stimulus source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected status word
  function automatic logic [31:0] stat();
    return {24'h0, ill, lock, mr1[0], mr1[12], mr1[7], 1'b0, st};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A wait that ran out is a mismatch and ends the run
  task automatic expire();
    error_cnt++;
    $display("Error at %0t: bus wait ran out", $time);
    test_done();
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // Write: both channels offered, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 40) expire();
    chk(bresp, er);
  endtask
  // Read: data compared only on an OKAY answer
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 40) expire();
    chk(rresp, er);
    if (er == 2'h0) chk(rdata, ed);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk({dq_oe, dll_locked}, 3'h0);
    rd(4'h4, stat(), 2'h0);
    rd(4'h0, 32'h0, 2'h0);
    rd(4'hc, 32'h0, 2'h2);
    wr(4'hc, 32'hffff_ffff, 2'h2);
    // Byte lane 0 disabled: write answered but without effect
    wstrb <= 4'he;
    wr(4'h0, 32'h1, 2'h0);
    wstrb <= 4'hf;
    rd(4'h0, 32'h0, 2'h0);
    $display("test registers done");
    // Leveling entry: data termination stays off, nominal termination an allowed code
    dwl_ctrl_model_i.mrs(3'h1, 16'h0084);
    mr1 = 16'h0084;
    w(2);
    chk({dq_oe, dqs_term, dq_term}, 4'b1100);
    dwl_ctrl_model_i.set_odt(1'b1);
    w(2);
    chk({dqs_term, dq_term}, 2'b10);
    rd(4'h4, stat(), 2'h0);
    // Feedback per lane, prime line then all lines
    for (i = 0; i < 8; i++) begin
      if (i == 4) begin
        wr(4'h0, 32'h1, 2'h0);
        alldq = 1'b1;
      end
      lane = i % 2;
      rnd = lfsr(rnd);
      // Once locked, the strobe keeps landing on a high clock
      v = dly_lock[lane] | rnd[0];
      last_v[lane] = v;
      dwl_ctrl_model_i.pulse(lane, v);
      w(2);
      chk(dq_out[lane*8 +: 8], alldq ? {8{v}} : {7'h0, v});
      // Delay frozen at the first 0-to-1 step of the feedback
      if (!fb_last[lane] && v) dly_lock[lane] = 1'b1;
      fb_last[lane] = v;
    end
    // Enable low: a strobe changes nothing
    @(posedge aclk);
    ce <= 1'b0;
    dwl_ctrl_model_i.pulse(0, ~last_v[0]);
    w(2);
    chk(dq_out[7:0], {8{last_v[0]}});
    @(posedge aclk);
    ce <= 1'b1;
    $display("test feedback done");
    dwl_ctrl_model_i.mrs(3'h1, 16'h1080);
    mr1 = 16'h1080;
    rd(4'h4, stat(), 2'h0);
    rd(4'h8, {16'h0, mr1}, 2'h0);
    dwl_ctrl_model_i.set_odt(1'b0);
    w(2);
    chk({dqs_term, dq_term}, 2'b00);
    dwl_ctrl_model_i.mrs(3'h1, 16'h0000);
    mr1 = 16'h0;
    w(2);
    chk({dq_oe, dq_out}, 18'h0);
    // Outside leveling ODT drives both terminations when enabled
    dwl_ctrl_model_i.mrs(3'h1, 16'h0004);
    mr1 = 16'h0004;
    dwl_ctrl_model_i.set_odt(1'b1);
    w(2);
    chk({dqs_term, dq_term}, 2'b11);
    dwl_ctrl_model_i.set_odt(1'b0);
    dwl_ctrl_model_i.mrs(3'h1, 16'h0000);
    mr1 = 16'h0;
    $display("test leveling exit done");
    // Relock count after DLL reset, latencies rewritten meanwhile
    dwl_ctrl_model_i.mrs(3'h0, 16'h0100);
    dwl_ctrl_model_i.mrs(3'h0, 16'h0000);
    w(509);
    chk(dll_locked, 1'b0);
    w(1);
    chk(dll_locked, 1'b1);
    lock = 1'b1;
    $display("test relock done");
    // Clock change in self-refresh, power-down, then idle
    for (i = 1; i < 4; i++) begin
      if (i < 3) dwl_ctrl_model_i.low_power(i == 1);
      st = (i < 3) ? 2'(i) : 2'h0;
      rd(4'h4, stat(), 2'h0);
      dwl_ctrl_model_i.clk_change();
      lock = 1'b0;
      ill = (i == 3);
      rd(4'h4, stat(), 2'h0);
      dwl_ctrl_model_i.wake();
      st = 2'h0;
      // DLL reset after the exit, CKE held high through relock
      dwl_ctrl_model_i.mrs(3'h0, 16'h0100);
      w(512);
      chk(dll_locked, 1'b1);
      lock = 1'b1;
    end
    wr(4'h4, 32'h80, 2'h0);
    ill = 1'b0;
    rd(4'h4, stat(), 2'h0);
    $display("test clock change done");
    test_done();
  end
endmodule
